// ===== qsd_regs.svh
`ifndef QSD_REGS_SVH
`define QSD_REGS_SVH

// array geometry: four banks of rows by columns of 32-bit words
`define QSD_BANKS 4
`define QSD_ROWS 2048
`define QSD_COLS 256
`define QSD_WORDS (`QSD_BANKS * `QSD_ROWS * `QSD_COLS)

// system clock rate
`define QSD_CLK_MHZ 125

// self-timed row close after an auto precharge or precharge command
`define QSD_T_PRECHARGE_NS 20
`define QSD_PRECHARGE_CYC ((`QSD_T_PRECHARGE_NS * `QSD_CLK_MHZ + 999) / 1000)

// average spacing of one row refresh, used by the internal self refresh timer
`define QSD_T_REF_ROW_NS 15600
`define QSD_REF_ROW_CYC ((`QSD_T_REF_ROW_NS * `QSD_CLK_MHZ) / 1000)

// register byte offsets, decoded on the low address byte
`define QSD_OFS_MODE 8'h00
`define QSD_OFS_STATUS 8'h04
`define QSD_OFS_REFCNT 8'h08

// mode register fields and reset value
`define QSD_MODE_BL 2:0
`define QSD_MODE_IL 3
`define QSD_MODE_LAT 5:4
`define QSD_MODE_RESET 6'h30
`define QSD_BL_FULL 3'h7

// status register fields
`define QSD_ST_OPEN 3:0
`define QSD_ST_PRE 7:4
`define QSD_ST_BURST 9:8
`define QSD_ST_PWR 11:10
`define QSD_ST_REFROW 23:12

// address bit carrying auto precharge, or all banks on a precharge
`define QSD_AP_BIT 10

`endif

// ===== qsd_pkg.sv
package qsd_pkg;

	// command encoding of {ras_n, cas_n, we_n} with chip select low
	typedef enum logic [2:0] {
		CMD_MODE = 3'b000,
		CMD_REFRESH = 3'b001,
		CMD_PRECHARGE = 3'b010,
		CMD_ACTIVATE = 3'b011,
		CMD_WRITE = 3'b100,
		CMD_READ = 3'b101,
		CMD_TERMINATE = 3'b110,
		CMD_NOP = 3'b111
	} qsd_cmd_t;

	// burst engine states
	typedef enum logic [1:0] {
		BST_IDLE = 2'b00,
		BST_READ = 2'b01,
		BST_WRITE = 2'b10
	} qsd_bst_t;

	// power states
	typedef enum logic [1:0] {
		PWR_NORMAL = 2'b00,
		PWR_DOWN = 2'b01,
		PWR_SELF = 2'b10
	} qsd_pwr_t;

endpackage : qsd_pkg

// ===== qsd_mem_if.sv
`timescale 1ns/100ps
`default_nettype none

// one word access per cycle between burst engine and storage
interface qsd_mem_if;
	logic we; // write strobe for this cycle
	logic [1:0] bank; // bank of the access
	logic [10:0] row; // open row of that bank
	logic [7:0] col; // column of the access
	logic [31:0] wdata; // word to store
	logic [31:0] rdata; // word at bank/row/col, combinational

	modport core (output we, output bank, output row, output col, output wdata, input rdata);
	modport store (input we, input bank, input row, input col, input wdata, output rdata);
endinterface : qsd_mem_if

`default_nettype wire

// ===== qsd_array.sv
`timescale 1ns/100ps
`default_nettype none
`include "qsd_regs.svh"

// word storage for all four banks, flat index {bank, row, col}
module qsd_array (
	input wire logic clk_sys_i,
	input wire logic ce_i,
	qsd_mem_if.store port
);

	// contents are not reset; a real array holds garbage at power up
	logic [31:0] mem [0:`QSD_WORDS-1];

	// asynchronous read so a latency of one cycle can be met
	assign port.rdata = mem[{port.bank, port.row, port.col}];

	// write at the edge on which the word is on the data pins
	always_ff @(posedge clk_sys_i) begin
		if (ce_i && port.we) begin
			mem[{port.bank, port.row, port.col}] <= port.wdata;
		end
	end

endmodule : qsd_array

`default_nettype wire

// ===== qsd_core.sv
// Overview of operation
// - all pins sampled on rising clock edge
// - four banks, 2048 rows, 256 32-bit columns
// - access needs activate before read or write
// - activate takes bank bits and row
// - column command takes eight-bit start column
// - bursts walk columns internally in programmed order; here page bursts always run in sequential order
// - burst length 1,2,4,8,page; terminate stops
// - auto precharge closes row after burst; here page bursts never self-close
// - new column command accepted every cycle
// - read latency one, two or three cycles
// - precharge one bank while another bursts
// - concurrent auto precharge; auto refresh command
// - power-down and self refresh modes
//
// The register offsets and the AHB-Lite register port were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
`include "qsd_regs.svh"

module qsd_core (
	input wire logic clk_sys_i,
	input wire logic resetn_i,
	input wire logic ce_i,
	input wire logic mem_cke_i,
	input wire logic cs_n_i,
	input wire logic ras_n_i,
	input wire logic cas_n_i,
	input wire logic we_n_i,
	input wire logic bank_select_lo_i,
	input wire logic bank_select_hi_i,
	input wire logic [10:0] addr_i,
	input wire logic [31:0] dq_i,
	output logic [31:0] dq_o,
	output logic dq_oe_n_o,
	input wire logic hsel_i,
	input wire logic [31:0] haddr_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic [2:0] hsize_i,
	input wire logic [31:0] hwdata_i,
	input wire logic hready_i,
	output logic [31:0] hrdata_o,
	output logic hreadyout_o,
	output logic hresp_o
);

	// storage link
	qsd_mem_if mem_if ();

	// mode register: burst code, interleave, read latency
	logic [5:0] mode;
	logic [8:0] bl_len; // burst length in words
	logic bl_full; // whole-row burst selected

	// per-bank state
	logic bank_open [`QSD_BANKS]; // row is open
	logic [10:0] bank_row [`QSD_BANKS]; // which row
	logic [3:0] pre_cnt [`QSD_BANKS]; // precharge cycles left
	logic bank_idle [`QSD_BANKS]; // closed and precharge done
	logic ap_hit [`QSD_BANKS]; // auto precharge starts now
	logic [3:0] open_v; // packed for status
	logic [3:0] pre_v; // packed for status
	logic all_idle; // every bank closed and settled

	// command decode
	qsd_pkg::qsd_cmd_t cmd; // decoded command, nop when not live
	logic [1:0] cmd_bank; // bank select pins
	logic cmd_live; // commands are honoured this cycle
	logic col_go; // read or write accepted
	logic self_enter; // refresh with clock enable low

	// burst engine
	qsd_pkg::qsd_bst_t bst;
	logic [1:0] bst_bank;
	logic [10:0] bst_row;
	logic [7:0] bst_start; // start column
	logic [8:0] bst_idx; // next location in burst
	logic [8:0] bst_len;
	logic [7:0] bst_mask; // wrap boundary of the burst
	logic bst_il; // interleaved order
	logic bst_full; // page burst, runs until stopped
	logic bst_ap; // auto precharge on completion
	logic bst_run; // burst advances this cycle
	logic bst_last; // this access is the final location
	logic bst_stop; // terminate or precharge cuts the burst
	logic old_end; // running burst ends this cycle
	logic new_single; // accepted command is a one-word burst

	// current array access
	logic acc_en;
	logic acc_wr;

	// read data pipeline
	logic [31:0] pipe1;
	logic [31:0] pipe2;
	logic pipe1_v;
	logic pipe2_v;
	logic rd_now; // a read word leaves the array now
	logic wr_kill; // write command claims the data pins

	// power and refresh
	qsd_pkg::qsd_pwr_t pwr;
	logic [10:0] self_tick; // self refresh row timer
	logic self_fire; // internal row refresh
	logic ref_ok; // auto refresh accepted
	logic [11:0] ref_row; // next row to refresh
	logic [15:0] ref_total; // auto refresh commands taken

	// register bus
	logic a_valid; // data phase pending
	logic a_write;
	logic [7:0] a_ofs;
	logic a_take; // address phase accepted
	logic [31:0] rd_word;

	// column order inside the burst boundary
	function automatic logic [7:0] burst_col(input logic [7:0] start, input logic [7:0] idx,
			input logic [7:0] mask, input logic il);
		logic [7:0] low;
		low = il ? (start ^ idx) : 8'(start + idx);
		return (start & ~mask) | (low & mask);
	endfunction : burst_col

	// burst length from mode code; reserved codes act as one word
	always_comb begin
		bl_full = (mode[`QSD_MODE_BL] == `QSD_BL_FULL);
		case (mode[`QSD_MODE_BL])
			3'h0: bl_len = 9'h001;
			3'h1: bl_len = 9'h002;
			3'h2: bl_len = 9'h004;
			3'h3: bl_len = 9'h008;
			`QSD_BL_FULL: bl_len = 9'h100;
			default: bl_len = 9'h001;
		endcase
	end

	// pins are synchronous to this clock, used at the edge they are sampled
	assign cmd_bank = {bank_select_hi_i, bank_select_lo_i};
	assign cmd_live = ce_i && mem_cke_i && (pwr == qsd_pkg::PWR_NORMAL);
	assign self_enter = ce_i && !mem_cke_i && !cs_n_i && (pwr == qsd_pkg::PWR_NORMAL)
		&& ({ras_n_i, cas_n_i, we_n_i} == qsd_pkg::CMD_REFRESH) && all_idle
		&& (bst == qsd_pkg::BST_IDLE);

	// command decode, deselected or frozen reads as nop
	always_comb begin
		cmd = qsd_pkg::CMD_NOP;
		if (!cs_n_i && cmd_live) begin
			cmd = qsd_pkg::qsd_cmd_t'({ras_n_i, cas_n_i, we_n_i});
		end
	end

	// column command only lands on an open bank; others are dropped
	assign col_go = ((cmd == qsd_pkg::CMD_READ) || (cmd == qsd_pkg::CMD_WRITE))
		&& bank_open[cmd_bank];
	assign new_single = col_go && (bl_len == 9'h001);

	// burst control terms
	assign bst_run = (bst != qsd_pkg::BST_IDLE) && ce_i && mem_cke_i;
	assign bst_last = !bst_full && (bst_idx == bst_len - 9'h001);
	assign bst_stop = (cmd == qsd_pkg::CMD_TERMINATE) || ((cmd == qsd_pkg::CMD_PRECHARGE)
		&& (addr_i[`QSD_AP_BIT] || (cmd_bank == bst_bank)));
	assign old_end = (bst != qsd_pkg::BST_IDLE) && (col_go || bst_stop || (bst_run && bst_last));

	// pack bank state for status and refresh checks
	always_comb begin
		all_idle = 1'h1;
		for (int i = 0; i < `QSD_BANKS; i++) begin
			open_v[i] = bank_open[i];
			pre_v[i] = (pre_cnt[i] != 4'h0);
			all_idle = all_idle && bank_idle[i];
		end
	end

	// per-bank row state; banks run independently of each other
	for (genvar b = 0; b < `QSD_BANKS; b++) begin : g_bank
		logic pre_hit; // this bank starts closing

		// auto precharge of the ended burst, or of a one-word access now
		assign ap_hit[b] = (old_end && bst_ap && (bst_bank == 2'(b)))
			|| (new_single && addr_i[`QSD_AP_BIT] && (cmd_bank == 2'(b)));
		assign pre_hit = ap_hit[b] || ((cmd == qsd_pkg::CMD_PRECHARGE)
			&& (addr_i[`QSD_AP_BIT] || (cmd_bank == 2'(b))));
		assign bank_idle[b] = !bank_open[b] && (pre_cnt[b] == 4'h0);

		// open on activate, close on precharge, then count settle time
		always_ff @(posedge clk_sys_i or negedge resetn_i) begin
			if (!resetn_i) begin
				bank_open[b] <= 1'h0;
				bank_row[b] <= 11'h000;
				pre_cnt[b] <= 4'h0;
			end else if (ce_i) begin
				if (pre_hit) begin
					bank_open[b] <= 1'h0;
					pre_cnt[b] <= 4'(`QSD_PRECHARGE_CYC);
				end else if ((cmd == qsd_pkg::CMD_ACTIVATE) && (cmd_bank == 2'(b))
						&& bank_idle[b]) begin
					bank_open[b] <= 1'h1;
					bank_row[b] <= addr_i;
				end else if (pre_cnt[b] != 4'h0) begin
					pre_cnt[b] <= pre_cnt[b] - 4'h1;
				end
			end
		end
	end

	// pick this cycle's array access: a new command beats the old burst
	always_comb begin
		acc_en = 1'h0;
		acc_wr = 1'h0;
		mem_if.bank = bst_bank;
		mem_if.row = bst_row;
		mem_if.col = burst_col(bst_start, bst_idx[7:0], bst_mask, bst_il);
		if (col_go) begin
			acc_en = 1'h1;
			acc_wr = (cmd == qsd_pkg::CMD_WRITE);
			mem_if.bank = cmd_bank;
			mem_if.row = bank_row[cmd_bank];
			mem_if.col = addr_i[7:0];
		end else if (bst_run && !bst_stop) begin
			acc_en = 1'h1;
			acc_wr = (bst == qsd_pkg::BST_WRITE);
		end
	end

	// write data is taken from the pins at the edge of its access
	assign mem_if.we = acc_en && acc_wr;
	assign mem_if.wdata = dq_i;

	// storage for all banks, rows and columns
	qsd_array u_array (
		.clk_sys_i(clk_sys_i),
		.ce_i(ce_i),
		.port(mem_if.store)
	);

	// burst engine: one location per cycle until length, stop or new command
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			bst <= qsd_pkg::BST_IDLE;
			bst_bank <= 2'h0;
			bst_row <= 11'h000;
			bst_start <= 8'h00;
			bst_idx <= 9'h000;
			bst_len <= 9'h001;
			bst_mask <= 8'h00;
			bst_il <= 1'h0;
			bst_full <= 1'h0;
			bst_ap <= 1'h0;
		end else if (ce_i) begin
			if (col_go) begin
				// a new command interrupts any burst in flight
				if (new_single) begin
					bst <= qsd_pkg::BST_IDLE;
				end else if (cmd == qsd_pkg::CMD_WRITE) begin
					bst <= qsd_pkg::BST_WRITE;
				end else begin
					bst <= qsd_pkg::BST_READ;
				end
				bst_bank <= cmd_bank;
				bst_row <= bank_row[cmd_bank];
				bst_start <= addr_i[7:0];
				bst_idx <= 9'h001;
				bst_len <= bl_len;
				bst_mask <= 8'(bl_len - 9'h001);
				bst_il <= mode[`QSD_MODE_IL] && !bl_full; // page bursts run in order
				bst_full <= bl_full;
				bst_ap <= addr_i[`QSD_AP_BIT] && !bl_full; // page bursts never self-close
			end else begin
				case (bst)
					qsd_pkg::BST_READ, qsd_pkg::BST_WRITE: begin
						if (bst_stop) begin
							bst <= qsd_pkg::BST_IDLE;
						end else if (bst_run && bst_last) begin
							bst <= qsd_pkg::BST_IDLE;
						end else if (bst_run) begin
							bst_idx <= bst_idx + 9'h001;
						end
					end
					default: bst <= qsd_pkg::BST_IDLE;
				endcase
			end
		end
	end

	// a write command takes the pins, so queued read words are dropped
	assign rd_now = acc_en && !acc_wr;
	assign wr_kill = col_go && (cmd == qsd_pkg::CMD_WRITE);

	// read pipeline; clock enable low suspends it with the burst
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			pipe1 <= 32'h0000_0000;
			pipe2 <= 32'h0000_0000;
			pipe1_v <= 1'h0;
			pipe2_v <= 1'h0;
		end else if (ce_i && mem_cke_i) begin
			pipe1 <= mem_if.rdata;
			pipe1_v <= rd_now;
			pipe2 <= pipe1;
			pipe2_v <= pipe1_v && !wr_kill;
		end
	end

	// data pins: word leaves the array, waits latency minus one stages
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			dq_o <= 32'h0000_0000;
			dq_oe_n_o <= 1'h1;
		end else if (ce_i && mem_cke_i) begin
			case (mode[`QSD_MODE_LAT])
				2'h2: begin
					dq_o <= pipe1;
					dq_oe_n_o <= !(pipe1_v && !wr_kill);
				end
				2'h3: begin
					dq_o <= pipe2;
					dq_oe_n_o <= !(pipe2_v && !wr_kill);
				end
				default: begin
					// latency one; code zero is treated the same
					dq_o <= mem_if.rdata;
					dq_oe_n_o <= !rd_now;
				end
			endcase
		end
	end

	// power state: power-down when idle with clock enable low
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			pwr <= qsd_pkg::PWR_NORMAL;
		end else if (ce_i) begin
			case (pwr)
				qsd_pkg::PWR_NORMAL: begin
					if (self_enter) begin
						pwr <= qsd_pkg::PWR_SELF;
					end else if (!mem_cke_i && (bst == qsd_pkg::BST_IDLE)) begin
						pwr <= qsd_pkg::PWR_DOWN;
					end
				end
				qsd_pkg::PWR_DOWN, qsd_pkg::PWR_SELF: begin
					if (mem_cke_i) begin
						pwr <= qsd_pkg::PWR_NORMAL;
					end
				end
				default: pwr <= qsd_pkg::PWR_NORMAL;
			endcase
		end
	end

	// self refresh walks rows on its own timer, no commands needed
	assign self_fire = (pwr == qsd_pkg::PWR_SELF)
		&& (self_tick == 11'(`QSD_REF_ROW_CYC - 1));
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			self_tick <= 11'h000;
		end else if (ce_i) begin
			if ((pwr != qsd_pkg::PWR_SELF) || self_fire) begin
				self_tick <= 11'h000;
			end else begin
				self_tick <= self_tick + 11'h001;
			end
		end
	end

	// auto refresh only with every bank closed; row pointer shared
	assign ref_ok = (cmd == qsd_pkg::CMD_REFRESH) && all_idle && (bst == qsd_pkg::BST_IDLE);
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			ref_row <= 12'h000;
			ref_total <= 16'h0000;
		end else if (ce_i) begin
			if (ref_ok || self_enter || self_fire) begin
				ref_row <= ref_row + 12'h001;
			end
			if (ref_ok) begin
				ref_total <= ref_total + 16'h0001;
			end
		end
	end

	// mode register: load command from pins beats a bus write
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			mode <= `QSD_MODE_RESET;
		end else if ((cmd == qsd_pkg::CMD_MODE) && all_idle && (bst == qsd_pkg::BST_IDLE)) begin
			mode <= addr_i[5:0];
		end else if (a_valid && a_write && (a_ofs == `QSD_OFS_MODE)) begin
			mode <= hwdata_i[5:0];
		end
	end

	// bus address phase; only the low byte decodes, so the map repeats
	assign a_take = hsel_i && htrans_i[1] && hready_i;
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			a_valid <= 1'h0;
			a_write <= 1'h0;
			a_ofs <= 8'h00;
		end else begin
			// the bus side keeps running while the core is frozen
			a_valid <= a_take;
			if (a_take) begin
				a_write <= hwrite_i;
				a_ofs <= haddr_i[7:0];
			end
		end
	end

	// read mux; unmapped offsets read zero
	always_comb begin
		rd_word = 32'h0000_0000;
		case (haddr_i[7:0])
			`QSD_OFS_MODE: rd_word[5:0] = mode;
			`QSD_OFS_STATUS: begin
				rd_word[`QSD_ST_OPEN] = open_v;
				rd_word[`QSD_ST_PRE] = pre_v;
				rd_word[`QSD_ST_BURST] = bst;
				rd_word[`QSD_ST_PWR] = pwr;
				rd_word[`QSD_ST_REFROW] = ref_row;
			end
			`QSD_OFS_REFCNT: rd_word[15:0] = ref_total;
			default: rd_word = 32'h0000_0000;
		endcase
	end

	// zero wait state slave, always okay; read data set up at address phase
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			hrdata_o <= 32'h0000_0000;
			hreadyout_o <= 1'h1;
			hresp_o <= 1'h0;
		end else begin
			hreadyout_o <= 1'h1;
			hresp_o <= 1'h0;
			if (a_take && !hwrite_i) begin
				hrdata_o <= rd_word;
			end else begin
				hrdata_o <= 32'h0000_0000;
			end
		end
	end

	// transfer size is not checked; only whole words are expected
	logic unused_size;
	assign unused_size = ^hsize_i;

endmodule : qsd_core

`default_nettype wire

// ===== qsd_core_properties.sv
`timescale 1ns/100ps
`default_nettype none

// timing relations seen at the core's pins and bus ports
module qsd_core_chk (
	input wire logic clk_sys_i,
	input wire logic resetn_i,
	input wire logic ce_i,
	input wire logic mem_cke_i,
	input wire logic cs_n_i,
	input wire logic ras_n_i,
	input wire logic cas_n_i,
	input wire logic we_n_i,
	input wire logic hsel_i,
	input wire logic [31:0] haddr_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic hready_i,
	input wire logic [31:0] dq_o,
	input wire logic dq_oe_n_o,
	input wire logic [31:0] hrdata_o,
	input wire logic hreadyout_o,
	input wire logic hresp_o
);
	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (!resetn_i);
	// read on the pins, before bank and power gating, so a superset
	wire logic rd = ce_i && mem_cke_i && !cs_n_i && {ras_n_i, cas_n_i, we_n_i} == 3'b101;
	// bus read address phase
	wire logic brd = hsel_i && htrans_i[1] && hready_i && !hwrite_i;

	a_ready_high: assert property (hreadyout_o)
		else $error("hready low");
	a_resp_okay: assert property (!hresp_o)
		else $error("error response");
	a_rdata_idle: assert property (!brd |=> hrdata_o == 32'h0000_0000)
		else $error("read data outside read");
	a_hole_zero: assert property (
		brd && haddr_i[7:0] == 8'h0C |=> hrdata_o == 32'h0000_0000) else $error("hole read");
	a_reset_quiet: assert property (
		$rose(resetn_i) |-> dq_oe_n_o && hrdata_o == 32'h0000_0000) else $error("not quiet");
	// latency is at most three, so a fresh drive needs a recent read
	a_drive_cause: assert property ($fell(dq_oe_n_o) |->
		$past(rd) || $past(rd, 2) || $past(rd, 3)) else $error("drive without read");
	a_ce_freeze: assert property (!ce_i |=> $stable(dq_oe_n_o) && $stable(dq_o))
		else $error("pins moved while frozen");
	a_suspend_hold: assert property (ce_i && !mem_cke_i |=> $stable(dq_oe_n_o))
		else $error("drive moved in suspend");

	c_bus_read: cover property (brd);
	c_read_drive: cover property ($fell(dq_oe_n_o));
	c_suspend: cover property (!mem_cke_i);
endmodule : qsd_core_chk

bind qsd_core qsd_core_chk i_chk (.clk_sys_i, .resetn_i, .ce_i, .mem_cke_i, .cs_n_i, .ras_n_i,
	.cas_n_i, .we_n_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i, .hready_i, .dq_o, .dq_oe_n_o,
	.hrdata_o, .hreadyout_o, .hresp_o);

`default_nettype wire

// ===== qsd_ctl_model.sv
`timescale 1ns/100ps
`default_nettype none

// memory controller side of the pin interface
module qsd_ctl_model (
	input wire logic clk_sys_i,
	output logic cke_o = 1'b1,
	output logic cs_n_o = 1'b1,
	output logic [2:0] cmd_o = 3'b111,
	output logic [1:0] ba_o = 2'b00,
	output logic [10:0] addr_o = 11'h000,
	output logic [31:0] dq_o
);
	logic drv = 1'b0; // own word on the wire during a write burst
	logic [31:0] wd = 32'h0000_0000; // write word of this slot
	logic [31:0] pat = 32'h1357_9BDF; // stands in for a floating bus
	// undriven data changes every cycle so stale words never match
	always_ff @(posedge clk_sys_i) pat <= {pat[30:0], ~pat[31]};
	assign dq_o = drv ? wd : pat;

	// one slot: set after an edge, held until the next edge takes it
	task automatic cmd(input qsd_pkg::qsd_cmd_t c, input logic [1:0] b = 2'b00,
		input logic [10:0] a = 11'h000, input logic d = 1'b0,
		input logic [31:0] w = 32'h0000_0000, input logic k = 1'b1);
		@(posedge clk_sys_i);
		cke_o <= k;
		cs_n_o <= (c == qsd_pkg::CMD_NOP); // nop slots deselect the device
		cmd_o <= c;
		ba_o <= b;
		addr_o <= a;
		drv <= d;
		wd <= w;
	endtask : cmd
endmodule : qsd_ctl_model

`default_nettype wire

// ===== tb_top.sv
`timescale 1ns/100ps
`default_nettype none

module tb_top;
	logic clk_sys_i = 1'b0;
	logic resetn_i = 1'b0;
	logic ce_i = 1'b1;
	logic cke, cs_n, dq_oe_n_o, hreadyout_o, hresp_o, hsel = 1'b0, hwrite = 1'b0;
	logic [2:0] c3;
	logic [1:0] ba, htrans = 2'b00;
	logic [10:0] ad;
	logic [31:0] cdq, dq_o, hrdata_o, hr_q, haddr = '0, hwdata = '0;
	logic [31:0] w [4] = '{32'hC0DE_0001, 32'h5EED_0002, 32'hFACE_0003, 32'hBEAD_0004};
	int n_errors = 0;
	int n_tests = 0;
	wire logic [31:0] dq = dq_oe_n_o ? cdq : dq_o; // core wins while enabled

	qsd_core i_dut (.clk_sys_i, .resetn_i, .ce_i, .mem_cke_i(cke), .cs_n_i(cs_n),
		.ras_n_i(c3[2]), .cas_n_i(c3[1]), .we_n_i(c3[0]), .bank_select_lo_i(ba[0]),
		.bank_select_hi_i(ba[1]), .addr_i(ad), .dq_i(dq), .dq_o, .dq_oe_n_o, .hsel_i(hsel),
		.haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'b010),
		.hwdata_i(hwdata), .hready_i(hreadyout_o), .hrdata_o, .hreadyout_o, .hresp_o);
	qsd_ctl_model i_ctl (.clk_sys_i, .cke_o(cke), .cs_n_o(cs_n), .cmd_o(c3), .ba_o(ba),
		.addr_o(ad), .dq_o(cdq));

	initial forever #4 clk_sys_i = ~clk_sys_i;
	always @(posedge clk_sys_i) hr_q <= hrdata_o; // read data as sampled at the edge

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic close_out;
		$display("tests %0d errors %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : close_out

	// edge with hready high; only the watchdog ends a stuck wait
	task automatic bus_wait;
		@(posedge clk_sys_i);
		while (hreadyout_o !== 1'b1) @(posedge clk_sys_i);
	endtask : bus_wait

	// one single word transfer
	task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		@(posedge clk_sys_i);
		hsel <= 1'b1;
		htrans <= 2'b10;
		hwrite <= wr;
		haddr <= {24'h00_0000, a};
		bus_wait();
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		bus_wait();
		#1 q = hr_q;
	endtask : ahb

	task automatic nop;
		i_ctl.cmd(qsd_pkg::CMD_NOP);
	endtask : nop

	// read at bank b; word k expected to be w[ord[2k+:2]]
	task automatic rd_burst(input logic [1:0] b, input logic [10:0] a, input int lat,
		input int n, input logic [7:0] ord, input qsd_pkg::qsd_cmd_t c1 = qsd_pkg::CMD_NOP);
		i_ctl.cmd(qsd_pkg::CMD_READ, b, a);
		for (int j = 1; j <= lat + n; j++) begin
			i_ctl.cmd(j == 1 ? c1 : qsd_pkg::CMD_NOP, b);
			#1;
			if (j >= lat && j < lat + n) begin
				check("read word", dq_o, w[ord[2*(j-lat)+:2]]);
				check("drive", dq_oe_n_o, 1'b0);
			end else begin
				check("idle", dq_oe_n_o, 1'b1);
			end
		end
	endtask : rd_burst

	task automatic t_reset;
		logic [31:0] v;
		#1;
		check("oe after reset", dq_oe_n_o, 1'b1);
		ahb(1'b1, 8'h04, 32'hFFFF_FFFF, v); // status is read-only
		ahb(1'b1, 8'h0C, 32'hFFFF_FFFF, v); // hole in the map
		ahb(1'b0, 8'h00, 32'h0000_0000, v);
		check("mode", v, 32'h0000_0030);
		for (int i = 1; i < 4; i++) begin
			ahb(1'b0, 8'(4 * i), 32'h0000_0000, v);
			check("reg zero", v, 32'h0000_0000);
		end
	endtask : t_reset

	task automatic t_burst;
		logic [31:0] v;
		i_ctl.cmd(qsd_pkg::CMD_MODE, 2'd0, 11'h012); // pin load: burst 4, latency 1
		i_ctl.cmd(qsd_pkg::CMD_ACTIVATE, 2'd2, 11'h5A5);
		i_ctl.cmd(qsd_pkg::CMD_WRITE, 2'd2, 11'h006, 1'b1, w[0]);
		for (int k = 1; k < 4; k++) i_ctl.cmd(qsd_pkg::CMD_NOP, 2'd0, 11'h000, 1'b1, w[k]);
		nop();
		ahb(1'b0, 8'h04, 32'h0000_0000, v);
		check("bank open", v[3:0], 4'h4);
		for (int l = 1; l < 4; l++) begin
			ahb(1'b1, 8'h00, 32'h0000_0002 | (32'(l) << 4), v);
			rd_burst(2'd2, 11'h004, l, 4, 8'h4E); // wrap in the group of four
		end
		ahb(1'b1, 8'h00, 32'h0000_002A, v); // interleaved
		rd_burst(2'd2, 11'h005, 2, 4, 8'h1B);
		ahb(1'b1, 8'h00, 32'h0000_0011, v);
		rd_burst(2'd2, 11'h007, 1, 2, 8'h01);
		ahb(1'b1, 8'h00, 32'h0000_0012, v);
		rd_burst(2'd2, 11'h004, 1, 1, 8'h02, qsd_pkg::CMD_TERMINATE);
		ahb(1'b1, 8'h00, 32'h0000_0010, v); // one word, latency one
		i_ctl.cmd(qsd_pkg::CMD_READ, 2'd2, 11'h006);
		i_ctl.cmd(qsd_pkg::CMD_READ, 2'd2, 11'h005); // next cycle, other column
		#1;
		check("first of pair", dq_o, w[0]);
		nop();
		#1;
		check("second of pair", dq_o, w[3]);
		check("pair drive", dq_oe_n_o, 1'b0);
	endtask : t_burst

	task automatic t_close;
		logic [31:0] v;
		ahb(1'b1, 8'h00, 32'h0000_0010, v);
		rd_burst(2'd2, 11'h404, 1, 1, 8'h02); // with auto precharge
		repeat (4) nop();
		ahb(1'b0, 8'h04, 32'h0000_0000, v);
		check("row closed", v[7:0], 8'h00);
		rd_burst(2'd2, 11'h004, 3, 0, 8'h00); // closed bank gives nothing
		i_ctl.cmd(qsd_pkg::CMD_ACTIVATE, 2'd3, 11'h7FF);
		i_ctl.cmd(qsd_pkg::CMD_ACTIVATE, 2'd0, 11'h000);
		i_ctl.cmd(qsd_pkg::CMD_PRECHARGE, 2'd3);
		nop();
		ahb(1'b0, 8'h04, 32'h0000_0000, v);
		check("one bank closed", v[3:0], 4'h1);
		i_ctl.cmd(qsd_pkg::CMD_PRECHARGE, 2'd0, 11'h400); // all banks
		repeat (4) nop();
		ahb(1'b0, 8'h04, 32'h0000_0000, v);
		check("all closed", v[7:0], 8'h00);
	endtask : t_close

	task automatic t_power;
		logic [31:0] v;
		i_ctl.cmd(qsd_pkg::CMD_REFRESH);
		nop();
		ahb(1'b0, 8'h08, 32'h0000_0000, v);
		check("refresh count", v, 32'h0000_0001);
		i_ctl.cmd(qsd_pkg::CMD_REFRESH, 2'd0, 11'h000, 1'b0, 32'h0000_0000, 1'b0);
		ahb(1'b0, 8'h04, 32'h0000_0000, v);
		check("self refresh", v[11:10], 2'd2);
		nop();
		i_ctl.cmd(qsd_pkg::CMD_NOP, 2'd0, 11'h000, 1'b0, 32'h0000_0000, 1'b0);
		ahb(1'b0, 8'h04, 32'h0000_0000, v);
		check("power down", v[11:10], 2'd1);
		@(posedge clk_sys_i);
		ce_i <= 1'b0;
		repeat (2) @(posedge clk_sys_i);
		ce_i <= 1'b1;
		nop();
		ahb(1'b0, 8'h04, 32'h0000_0000, v);
		check("awake", v[11:10], 2'd0);
	endtask : t_power

	initial begin
		repeat (5) @(posedge clk_sys_i);
		resetn_i <= 1'b1;
		t_reset();
		t_burst();
		t_close();
		t_power();
		close_out();
	end

	// the whole run is under two hundred cycles
	initial begin
		#200000;
		n_errors++;
		close_out();
	end
endmodule : tb_top

`default_nettype wire
